// ==== hdl/tif_pkg.sv ====
// Package: register map, field layout and timing constants of the timer flag block
package tif_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_MASK1 = 3'h0;
  localparam logic [2:0] OFS_FLAG1 = 3'h1;
  localparam logic [2:0] OFS_MASK2 = 3'h2;
  localparam logic [2:0] OFS_FLAG2 = 3'h3;
  localparam logic [2:0] OFS_ACTL = 3'h4;
  localparam logic [2:0] OFS_CNT_HI = 3'h5;
  localparam logic [2:0] OFS_CNT_LO = 3'h6;
  localparam logic [2:0] OFS_MODE = 3'h7;
  // Second flag byte fields
  localparam int BIT_OVF = 7;
  localparam int BIT_TICK = 6;
  localparam int BIT_AOVF = 5;
  localparam int BIT_AEDGE = 4;
  // Control byte fields
  localparam int BIT_C5SEL = 2;
  localparam logic [7:0] MASK2_IMPL = 8'hf3;
  localparam logic [7:0] FLAG2_IMPL = 8'hf0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  // Prescaler: write window and divide ratios minus one
  localparam int PR_WINDOW_CYC = 64;
  localparam logic [6:0] PR_WINDOW = 7'(PR_WINDOW_CYC);
  localparam logic [3:0] PR_DIV1 = 4'h0;
  localparam logic [3:0] PR_DIV4 = 4'h3;
  localparam logic [3:0] PR_DIV8 = 4'h7;
  localparam logic [3:0] PR_DIV16 = 4'hf;
  // Tick base 2^13 bus clocks, rate codes add 0..3 further halvings
  localparam int TICK_BASE_LOG2 = 13;
  localparam int TICK_W = 16;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tif_bus_s;
  typedef struct packed {
    logic [3:0] compare;
    logic chan5;
    logic [2:0] capture;
  } tif_evt1_s;
  typedef struct packed {
    logic accum_overflow;
    logic accum_edge;
  } tif_evt2_s;
endpackage

// ==== hdl/tif_tick.sv ====
// Free-running periodic tick generator, independent of the counter prescaler
`timescale 1ns/1ps
module tif_tick import tif_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] rate,
  output logic tick
);
  logic [TICK_W-1:0] div_q;
  logic [TICK_W-1:0] limit;
  logic hit;

  // Period 2^(13+rate); the chain restarts only at timeout, never on flag clear
  assign limit = TICK_W'((32'h1 << (TICK_BASE_LOG2 + int'(rate))) - 1);
  assign hit = (div_q >= limit);

  // First tick after a whole period from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (hit) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + TICK_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= hit;
    end
  end
endmodule

// ==== hdl/tif_top.sv ====
// Timer interrupt mask/flag block with prescaled counter and periodic tick
//
// Contract
// - Compare flag and enable request interrupt
// - Channel five enable follows capture select
// - Capture flag and enable request interrupt
// - Enable bits align with their flags
// - Writing one clears that flag
// - Compare match sets compare flag
// - Select bit picks channel five source
// - Capture edge sets capture flag
// - Overflow enable gates overflow request
// - Prescale select writable once, early only, except in special mode
// - Prescale codes divide by 1,4,8,16
// - Unimplemented bits read zero
// - Counter wrap sets overflow flag
// - Tick period two to thirteen..sixteen
// - Tick independent of counter prescaler
// - Tick free running, timed from timeout
// - Timeout sets tick flag, enable gates
// - First tick after full period
// - Tick enable gates tick request
// - Accumulator rollover sets its flag
// - Accumulator edge sets its flag
`timescale 1ns/1ps
module tif_top import tif_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic special_mode,
  input wire logic [3:0] compare_match,
  input wire logic compare_five_match,
  input wire logic [2:0] capture_edge,
  input wire logic capture_four_edge,
  input wire logic accum_rollover,
  input wire logic accum_edge,
  output logic [15:0] free_running_counter,
  output logic chan5_capture_select,
  output logic [7:0] irq_one,
  output logic [3:0] irq_two
);
  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  tif_bus_s bus;
  tif_evt1_s evt1;
  tif_evt2_s evt2;
  logic [7:0] mask1_q;
  logic [7:0] flag1_q;
  logic [7:0] mask2_q;
  logic [7:0] flag2_q;
  logic [7:0] actl_q;
  logic [1:0] prescale_select;
  logic [6:0] win_q;
  logic pr_locked_q;
  logic [3:0] pre_q;
  logic [3:0] pre_lim;
  logic cnt_en;
  logic [15:0] cnt_q;
  logic tick;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] rd_d;
  logic [7:0] flag2_nx;
  logic [7:0] mask2_nx;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign prescale_select = mask2_q[1:0];

  // ---------------------------------------------------------------
  // Event collection
  // ---------------------------------------------------------------
  // Capture and compare strobes come from same-clock datapaths
  assign evt1.compare = compare_match;
  assign evt1.capture = capture_edge;
  // Only the function chosen by the select bit may set channel five
  assign evt1.chan5 = actl_q[BIT_C5SEL] ? capture_four_edge : compare_five_match;
  assign evt2.accum_overflow = accum_rollover;
  assign evt2.accum_edge = accum_edge;

  assign set1 = {evt1.compare, evt1.chan5, evt1.capture};
  assign set2 = {cnt_en && (cnt_q == CNT_ALL_ONES), tick,
                 evt2.accum_overflow, evt2.accum_edge, 4'h0};
  assign clr1 = (bus.wr && bus.addr == OFS_FLAG1) ? bus.wdata : 8'h00;
  assign clr2 = (bus.wr && bus.addr == OFS_FLAG2) ? (bus.wdata & FLAG2_IMPL) : 8'h00;
  // Next-state second flag and mask bytes, so requests line up with readable flags
  assign flag2_nx = (flag2_q & ~clr2) | set2;
  assign mask2_nx = (bus.wr && bus.addr == OFS_MASK2) ? bus.wdata : mask2_q;

  // ---------------------------------------------------------------
  // Flags: set wins over a clear in the same cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag1_q <= RESET_BYTE;
    end else begin
      flag1_q <= (flag1_q & ~clr1) | set1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag2_q <= RESET_BYTE;
    end else begin
      flag2_q <= ((flag2_q & ~clr2) | set2) & FLAG2_IMPL;
    end
  end

  // ---------------------------------------------------------------
  // Mask and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask1_q <= RESET_BYTE;
    end else if (bus.wr && bus.addr == OFS_MASK1) begin
      mask1_q <= bus.wdata;
    end
  end

  // Outside special mode the prescaler field takes one write in the first 64 cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask2_q <= RESET_BYTE;
    end else if (bus.wr && bus.addr == OFS_MASK2) begin
      mask2_q[7:4] <= bus.wdata[7:4];
      if (special_mode || (!pr_locked_q && win_q < PR_WINDOW)) begin
        mask2_q[1:0] <= bus.wdata[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= '0;
    end else if (win_q < PR_WINDOW) begin
      win_q <= win_q + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pr_locked_q <= 1'b0;
    end else if (bus.wr && bus.addr == OFS_MASK2 && !special_mode) begin
      pr_locked_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actl_q <= RESET_BYTE;
    end else if (bus.wr && bus.addr == OFS_ACTL) begin
      actl_q <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and free-running counter
  // ---------------------------------------------------------------
  always_comb begin
    unique case (prescale_select)
      2'h0: pre_lim = PR_DIV1;
      2'h1: pre_lim = PR_DIV4;
      2'h2: pre_lim = PR_DIV8;
      2'h3: pre_lim = PR_DIV16;
    endcase
  end

  assign cnt_en = (pre_q >= pre_lim);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (cnt_en) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= CNT_RESET;
    end else if (cnt_en) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Periodic tick
  // ---------------------------------------------------------------
  // Own divider from the bus clock, so the prescale field cannot stretch it
  tif_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .rate(actl_q[1:0]),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Read path and outputs
  // ---------------------------------------------------------------
  always_comb begin
    unique case (bus.addr)
      OFS_MASK1: rd_d = mask1_q;
      OFS_FLAG1: rd_d = flag1_q;
      OFS_MASK2: rd_d = mask2_q & MASK2_IMPL;
      OFS_FLAG2: rd_d = flag2_q & FLAG2_IMPL;
      OFS_ACTL: rd_d = actl_q;
      OFS_CNT_HI: rd_d = cnt_q[15:8];
      OFS_CNT_LO: rd_d = cnt_q[7:0];
      OFS_MODE: rd_d = {7'h00, pr_locked_q};
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RESET_BYTE;
    end else begin
      reg_rdata <= bus.rd ? rd_d : RESET_BYTE;
    end
  end

  // Requests are registered from next-state flags and masks, so they line up
  // with the flag bits software reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_one <= RESET_BYTE;
      irq_two <= 4'h0;
    end else begin
      irq_one <= ((flag1_q & ~clr1) | set1) &
                 ((bus.wr && bus.addr == OFS_MASK1) ? bus.wdata : mask1_q);
      irq_two <= flag2_nx[7:4] & mask2_nx[7:4];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      free_running_counter <= CNT_RESET;
      chan5_capture_select <= 1'b0;
    end else begin
      free_running_counter <= cnt_en ? cnt_q + 16'h0001 : cnt_q;
      chan5_capture_select <= (bus.wr && bus.addr == OFS_ACTL) ? bus.wdata[BIT_C5SEL]
                                                               : actl_q[BIT_C5SEL];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wrap;
    cnt_en && cnt_q == CNT_ALL_ONES;
  endsequence

  irq_track_a: assert property (##1 irq_one == (flag1_q & mask1_q))
    else $error("compare/capture request does not match flag and mask");
  irq_two_track_a: assert property (##1 irq_two == (flag2_q[7:4] & mask2_q[7:4]))
    else $error("second request byte does not match flag and mask");
  chan5_sel_a: assert property (actl_q[BIT_C5SEL] && compare_five_match && !capture_four_edge
                                && !flag1_q[3] |=> !flag1_q[3])
    else $error("channel five set by deselected source");
  clear_one_a: assert property (bus.wr && bus.addr == OFS_FLAG1 && bus.wdata[7] && !set1[7]
                                |=> !flag1_q[7])
    else $error("write one did not clear flag");
  set_wins_a: assert property (set1[0] && clr1[0] |=> flag1_q[0])
    else $error("clear beat a simultaneous set");
  wrap_flag_a: assert property (s_wrap |=> flag2_q[BIT_OVF] && cnt_q == CNT_RESET)
    else $error("counter wrap did not set overflow flag");
  pr_lock_a: assert property (!special_mode && pr_locked_q |=> $stable(mask2_q[1:0]))
    else $error("prescale field changed after lock");
  pr_late_a: assert property (!special_mode && win_q == PR_WINDOW |=> $stable(mask2_q[1:0]))
    else $error("prescale field written after window");
  zero_bits_a: assert property (bus.rd && bus.addr == OFS_FLAG2 |=> reg_rdata[3:0] == 4'h0)
    else $error("unimplemented flag bits read nonzero");
  tick_sets_a: assert property (tick |=> flag2_q[BIT_TICK])
    else $error("tick did not set tick flag");
  div_one_a: assert property (prescale_select == 2'h0 |-> cnt_en)
    else $error("divide-by-one not counting every cycle");
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the timer flag block
`timescale 1ns/1ps
module testbench;
  import tif_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] cm = 4'h0;
  logic c5m = 1'b0;
  logic [2:0] ce = 3'h0;
  logic c4e = 1'b0;
  logic aro = 1'b0;
  logic aed = 1'b0;
  logic [15:0] cnt;
  logic [15:0] c0;
  logic c5sel;
  logic sel;
  logic [7:0] irq1;
  logic [3:0] irq2;
  logic [7:0] m1;
  logic [7:0] f1;
  logic [7:0] v;
  logic [31:0] q;
  int num_errors = 0;
  int n_checks = 0;
  int i;
  longint t0;
  longint t1;
  longint t2;

  always #5 clk = ~clk;

  // Special mode stays low: only the normal-mode lock is exercised
  tif_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(1'b0),
    .compare_match(cm), .compare_five_match(c5m), .capture_edge(ce),
    .capture_four_edge(c4e), .accum_rollover(aro), .accum_edge(aed),
    .free_running_counter(cnt), .chan5_capture_select(c5sel), .irq_one(irq1), .irq_two(irq2));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang;
    num_errors++;
    close_out();
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  endtask

  // One-cycle event strobes; flags and requests land at the sampling edge
  task automatic ev(input logic [7:0] e, input logic c4, input logic c5, input logic [1:0] a);
    @(posedge clk);
    cm <= e[7:4];
    c4e <= c4;
    c5m <= c5;
    ce <= e[2:0];
    aro <= a[1];
    aed <= a[0];
    @(posedge clk);
    cm <= 4'h0;
    c4e <= 1'b0;
    c5m <= 1'b0;
    ce <= 3'h0;
    aro <= 1'b0;
    aed <= 1'b0;
    #1;
  endtask

  task automatic wait_tick(output longint t);
    for (i = 0; i < 9000 && irq2[2] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 9000) hang();
    t = $time;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(93));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(OFS_MASK2, 8'h01);
    rdc(OFS_MASK1, 8'h00);
    rdc(OFS_FLAG1, 8'h00);
    rdc(OFS_FLAG2, 8'h00);
    rdc(OFS_ACTL, 8'h00);
    wr(OFS_MASK2, 8'h03);
    rdc(OFS_MASK2, 8'h01);
    // Align to an increment, then ten divide-by-4 steps
    c0 = cnt;
    for (i = 0; i < 20 && cnt === c0; i++) begin
      @(posedge clk);
      #1;
    end
    c0 = cnt;
    repeat (40) @(posedge clk);
    #1;
    chk(cnt - c0, 16'h000a);
    sel = 1'b1;
    wr(OFS_ACTL, 8'h04);
    chk(16'(c5sel), 16'h0001);
    m1 = 8'h00;
    f1 = 8'h00;
    for (int k = 0; k < 24; k++) begin
      if (k == 12) begin
        sel = 1'b0;
        wr(OFS_ACTL, 8'h00);
      end
      v = 8'($urandom);
      wr(OFS_MASK1, v);
      m1 = v;
      q = $urandom;
      ev(q[7:0], q[8], q[9], 2'b00);
      f1 = f1 | {q[7:4], sel ? q[8] : q[9], q[2:0]};
      chk(16'(irq1), 16'(f1 & m1));
      rdc(OFS_FLAG1, f1);
      v = 8'($urandom);
      wr(OFS_FLAG1, v);
      f1 = f1 & ~v;
      chk(16'(irq1), 16'(f1 & m1));
    end
    wr(OFS_MASK1, 8'hff);
    wr(OFS_FLAG1, 8'hff);
    // Hardware set and a clearing write in the same cycle
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= OFS_FLAG1;
    reg_wdata <= 8'hff;
    cm <= 4'h8;
    @(posedge clk);
    reg_wr <= 1'b0;
    cm <= 4'h0;
    #1;
    chk(16'(irq1), 16'h0080);
    wr(OFS_MASK2, 8'hff);
    rdc(OFS_MASK2, 8'hf1);
    ev(8'h00, 1'b0, 1'b0, 2'b11);
    chk(16'(irq2[1:0]), 16'h0003);
    rdc(OFS_FLAG2, 8'h30);
    wr(OFS_FLAG2, 8'h2f);
    chk(16'(irq2[1:0]), 16'h0001);
    wr(OFS_FLAG2, 8'h10);
    chk(16'(irq2[1:0]), 16'h0000);
    wr(OFS_MASK2, 8'h00);
    ev(8'h00, 1'b0, 1'b0, 2'b11);
    chk(16'(irq2), 16'h0000);
    rdc(OFS_FLAG2, 8'h30);
    // Second reset: let the prescale window lapse before writing
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t0 = $time;
    repeat (70) @(posedge clk);
    wr(OFS_MASK2, 8'hc2);
    rdc(OFS_MASK2, 8'hc0);
    c0 = cnt;
    repeat (10) @(posedge clk);
    #1;
    chk(cnt - c0, 16'h000a);
    wait_tick(t1);
    chk(16'((t1 - t0) / 10 >= 8192 && (t1 - t0) / 10 <= 8195), 16'h0001);
    // Late clear must not stretch the period
    repeat (100) @(posedge clk);
    wr(OFS_FLAG2, 8'h40);
    chk(16'(irq2[2]), 16'h0000);
    wait_tick(t2);
    chk(16'((t2 - t1) / 10), 16'd8192);
    for (i = 0; i < 70000 && cnt !== 16'hffff; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 70000) hang();
    chk(16'(irq2[3]), 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(irq2[3]), 16'h0001);
    close_out();
  end
endmodule
